/* acio_defines.svh */
// register indexes, reset values and encodings of the address capable port
`ifndef ACIO_DEFINES_SVH
`define ACIO_DEFINES_SVH
// register indexes; byte address is four times the index
`define ACIO_IDX_DIRECTION 16'hFEBB
`define ACIO_IDX_PIN_STATE 16'hFF5B
`define ACIO_IDX_OUTPUT_LATCH 16'hFF6B
`define ACIO_IDX_PULLUP_ENABLE 16'hFF72
`define ACIO_ADDR_WIDTH 18
`define ACIO_IDX_LSB 2
// reset value of the port registers
`define ACIO_RESET_BYTE 8'h00
// value returned when the write-only direction register is read
`define ACIO_UNDEF_READ 8'h00
// operating mode codes on the mode pins
`define ACIO_MODE_2 3'h2
`define ACIO_MODE_3 3'h3
`define ACIO_MODE_6 3'h6
`define ACIO_MODE_7 3'h7
// bus responses
`define ACIO_RESP_OKAY 2'h0
`define ACIO_RESP_SLVERR 2'h2
`endif

/* acio_pkg.sv */
// types shared by the address capable port modules
package acio_pkg;
   // how the pins behave in the current operating mode
   typedef enum logic [1:0] {
      CLASS_ADDR,
      CLASS_ADDR_DDR,
      CLASS_GPIO
   } mode_class_type;
endpackage : acio_pkg

/* address_capable_io_port.sv */
// eight-bit port with address output function and AXI4-Lite registers
// Overview of operation
// - direction register write-only; reads give fixed value
// - direction clears on power-on/hardware standby only
// - standby keep bit holds or floats address
// - modes 1, 4, 5: all address outputs
// - modes 2, 6: direction one gives address
// - modes 3, 7: direction one drives latch
// - output latch read/write, cleared like direction
// - pin-state register read-only, writes ignored
// - pin-state read: latch if output, else pin
// - pin-state held in manual reset, software standby
// - pull-up enable read/write, cleared like direction
// - pull-up on when input and enabled
// - modes 1, 4, 5: pull-ups always off
// - pull-ups off after power-on/hardware standby
// - reduced variant supports modes 1, 4, 5
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "acio_defines.svh"
module address_capable_io_port #(
   parameter int WIDTH = 8,
   parameter bit REDUCED = 1'b0
) (
   // clock and power-on reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus write
   input wire logic [`ACIO_ADDR_WIDTH-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // register bus read
   input wire logic [`ACIO_ADDR_WIDTH-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // chip state
   input wire logic manual_reset,
   input wire logic sw_standby,
   input wire logic standby_output_keep,
   input wire logic hw_standby,
   input wire logic [2:0] mode_pins,
   // address from bus controller
   input wire logic [WIDTH-1:0] addr_bus,
   // port pins
   input wire logic [WIDTH-1:0] port_pin_in,
   output logic [WIDTH-1:0] port_pin_out,
   output logic [WIDTH-1:0] port_pin_oe,
   output logic [WIDTH-1:0] pullup_on
);
   localparam int IDX_W = `ACIO_ADDR_WIDTH - `ACIO_IDX_LSB;

   if (WIDTH < 1 || WIDTH > 8)
   begin : g_bad_width
      $error("WIDTH must be 1 to 8");
   end

   // all state of the port except the pin drive of u_mux in one register
   typedef struct packed {
      logic [2:0] mode_meta;
      logic [2:0] mode_sync;
      logic [WIDTH-1:0] pin_meta;
      logic [WIDTH-1:0] pin_sync;
      logic hws_meta;
      logic hws_sync;
      acio_pkg::mode_class_type mode_class;
      logic [WIDTH-1:0] dir;
      logic [WIDTH-1:0] latch;
      logic [WIDTH-1:0] pull_cfg;
      logic [WIDTH-1:0] pin_state;
      logic aw_ready;
      logic aw_held;
      logic [IDX_W-1:0] aw_idx;
      logic w_ready;
      logic w_held;
      logic [WIDTH-1:0] w_byte;
      logic w_lane0;
      logic b_valid;
      logic [1:0] b_resp;
      logic ar_ready;
      logic r_valid;
      logic [IDX_W-1:0] rd_idx;
      logic [31:0] r_data;
      logic [1:0] r_resp;
   } port_state_type;

   port_state_type state_reg;
   port_state_type state_next;
   logic wr_fire;
   logic wr_allowed;
   logic [WIDTH-1:0] pin_view;

   // helper terms shared with the checks below
   assign wr_fire = state_reg.aw_held && state_reg.w_held && !state_reg.b_valid;
   assign wr_allowed = !manual_reset && !state_reg.hws_sync && state_reg.w_lane0;
   assign pin_view = (state_reg.dir & state_reg.latch) | (~state_reg.dir & state_reg.pin_sync);

   // synchronisers, register file and bus slave
   always_comb
   begin
      state_next = state_reg;
      state_next.mode_meta = mode_pins;
      state_next.mode_sync = state_reg.mode_meta;
      state_next.pin_meta = port_pin_in;
      state_next.pin_sync = state_reg.pin_meta;
      state_next.hws_meta = hw_standby;
      state_next.hws_sync = state_reg.hws_meta;
      // operating mode class
      case (state_reg.mode_sync)
         `ACIO_MODE_2, `ACIO_MODE_6: state_next.mode_class = acio_pkg::CLASS_ADDR_DDR;
         `ACIO_MODE_3, `ACIO_MODE_7: state_next.mode_class = acio_pkg::CLASS_GPIO;
         default: state_next.mode_class = acio_pkg::CLASS_ADDR;
      endcase
      if (REDUCED)
         state_next.mode_class = acio_pkg::CLASS_ADDR;
      // pin-state capture; frozen in manual reset and software standby
      if (state_reg.hws_sync || !(manual_reset || sw_standby))
         state_next.pin_state = pin_view;
      // write address and data taken in either order
      if (state_reg.aw_ready && s_axi_awvalid)
      begin
         state_next.aw_held = 1'b1;
         state_next.aw_idx = s_axi_awaddr[`ACIO_ADDR_WIDTH-1:`ACIO_IDX_LSB];
      end
      if (state_reg.w_ready && s_axi_wvalid)
      begin
         state_next.w_held = 1'b1;
         state_next.w_byte = s_axi_wdata[WIDTH-1:0];
         state_next.w_lane0 = s_axi_wstrb[0];
      end
      // perform the write once both halves are in
      if (wr_fire)
      begin
         state_next.aw_held = 1'b0;
         state_next.w_held = 1'b0;
         state_next.b_valid = 1'b1;
         state_next.b_resp = `ACIO_RESP_OKAY;
         case (state_reg.aw_idx)
            IDX_W'(`ACIO_IDX_DIRECTION):
               if (wr_allowed)
                  state_next.dir = state_reg.w_byte;
            IDX_W'(`ACIO_IDX_OUTPUT_LATCH):
               if (wr_allowed)
                  state_next.latch = state_reg.w_byte;
            IDX_W'(`ACIO_IDX_PULLUP_ENABLE):
               if (wr_allowed)
                  state_next.pull_cfg = state_reg.w_byte;
            IDX_W'(`ACIO_IDX_PIN_STATE):
               state_next.b_resp = `ACIO_RESP_OKAY;
            default:
               state_next.b_resp = `ACIO_RESP_SLVERR;
         endcase
      end
      if (state_reg.b_valid && s_axi_bready)
         state_next.b_valid = 1'b0;
      state_next.aw_ready = !state_next.aw_held && !state_next.b_valid;
      state_next.w_ready = !state_next.w_held && !state_next.b_valid;
      // read path
      if (state_reg.ar_ready && s_axi_arvalid)
      begin
         state_next.r_valid = 1'b1;
         state_next.rd_idx = s_axi_araddr[`ACIO_ADDR_WIDTH-1:`ACIO_IDX_LSB];
         state_next.r_resp = `ACIO_RESP_OKAY;
         state_next.r_data = '0;
         case (s_axi_araddr[`ACIO_ADDR_WIDTH-1:`ACIO_IDX_LSB])
            IDX_W'(`ACIO_IDX_DIRECTION):
               state_next.r_data[WIDTH-1:0] = WIDTH'(`ACIO_UNDEF_READ);
            IDX_W'(`ACIO_IDX_OUTPUT_LATCH):
               state_next.r_data[WIDTH-1:0] = state_reg.latch;
            IDX_W'(`ACIO_IDX_PIN_STATE):
               state_next.r_data[WIDTH-1:0] = state_reg.pin_state;
            IDX_W'(`ACIO_IDX_PULLUP_ENABLE):
               state_next.r_data[WIDTH-1:0] = state_reg.pull_cfg;
            default:
               state_next.r_resp = `ACIO_RESP_SLVERR;
         endcase
      end
      if (state_reg.r_valid && s_axi_rready)
         state_next.r_valid = 1'b0;
      state_next.ar_ready = !state_next.r_valid;
      // hardware standby clears the port registers
      if (state_reg.hws_sync)
      begin
         state_next.dir = WIDTH'(`ACIO_RESET_BYTE);
         state_next.latch = WIDTH'(`ACIO_RESET_BYTE);
         state_next.pull_cfg = WIDTH'(`ACIO_RESET_BYTE);
      end
   end

   // state register; reset is the power-on reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= '0;
         state_reg.mode_class <= acio_pkg::CLASS_ADDR;
         state_reg.dir <= WIDTH'(`ACIO_RESET_BYTE);
         state_reg.latch <= WIDTH'(`ACIO_RESET_BYTE);
         state_reg.pull_cfg <= WIDTH'(`ACIO_RESET_BYTE);
      end
      else
         state_reg <= state_next;
   end

   // configuration towards the pin multiplexer
   pin_ctrl_if #(.WIDTH(WIDTH)) ctl ();
   assign ctl.dir = state_reg.dir;
   assign ctl.latch = state_reg.latch;
   assign ctl.pull_cfg = state_reg.pull_cfg;
   assign ctl.addr = addr_bus;
   assign ctl.mode_class = state_reg.mode_class;
   assign ctl.sw_standby = sw_standby;
   assign ctl.keep = standby_output_keep;
   assign ctl.hw_standby = state_reg.hws_sync;

   port_pin_mux #(
      .WIDTH(WIDTH)
   ) u_mux (
      .aclk(aclk),
      .aresetn(aresetn),
      .ctl(ctl.sink),
      .pin_out(port_pin_out),
      .pin_oe(port_pin_oe),
      .pullup_on(pullup_on)
   );

   // bus outputs straight from the state register
   assign s_axi_awready = state_reg.aw_ready;
   assign s_axi_wready = state_reg.w_ready;
   assign s_axi_bvalid = state_reg.b_valid;
   assign s_axi_bresp = state_reg.b_resp;
   assign s_axi_arready = state_reg.ar_ready;
   assign s_axi_rvalid = state_reg.r_valid;
   assign s_axi_rdata = state_reg.r_data;
   assign s_axi_rresp = state_reg.r_resp;

   default clocking port_clk @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // register file checks
   property p_dir_hidden;
      (s_axi_rvalid && state_reg.rd_idx == IDX_W'(`ACIO_IDX_DIRECTION))
         |-> (s_axi_rdata == 32'(`ACIO_UNDEF_READ));
   endproperty
   a_dir_hidden: assert property (p_dir_hidden)
      else $error("direction read returned stored value");
   property p_hws_clears;
      state_reg.hws_sync |=> (state_reg.dir == '0 && state_reg.latch == '0
         && state_reg.pull_cfg == '0);
   endproperty
   a_hws_clears: assert property (p_hws_clears)
      else $error("hardware standby did not clear registers");
   property p_manual_keeps;
      (manual_reset && !state_reg.hws_sync)
         |=> ($stable(state_reg.dir) && $stable(state_reg.latch) && $stable(state_reg.pull_cfg));
   endproperty
   a_manual_keeps: assert property (p_manual_keeps)
      else $error("register changed during manual reset");
   property p_pullcfg_write;
      (wr_fire && wr_allowed && state_reg.aw_idx == IDX_W'(`ACIO_IDX_PULLUP_ENABLE))
         |=> (state_reg.pull_cfg == $past(state_reg.w_byte));
   endproperty
   a_pullcfg_write: assert property (p_pullcfg_write)
      else $error("pull-up enable write lost");
   property p_pin_state_ro;
      (wr_fire && state_reg.aw_idx == IDX_W'(`ACIO_IDX_PIN_STATE) && !state_reg.hws_sync)
         |=> ($stable(state_reg.dir) && $stable(state_reg.latch) && $stable(state_reg.pull_cfg));
   endproperty
   a_pin_state_ro: assert property (p_pin_state_ro)
      else $error("pin-state write changed a register");
   property p_dir_write;
      (wr_fire && wr_allowed && state_reg.aw_idx == IDX_W'(`ACIO_IDX_DIRECTION))
         |=> (state_reg.dir == $past(state_reg.w_byte));
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("direction write lost");
   property p_latch_write;
      (wr_fire && wr_allowed && state_reg.aw_idx == IDX_W'(`ACIO_IDX_OUTPUT_LATCH))
         |=> (state_reg.latch == $past(state_reg.w_byte));
   endproperty
   a_latch_write: assert property (p_latch_write)
      else $error("output latch write lost");
   property p_lane_ignored;
      (wr_fire && !state_reg.w_lane0 && !state_reg.hws_sync)
         |=> ($stable(state_reg.dir) && $stable(state_reg.latch) && $stable(state_reg.pull_cfg));
   endproperty
   a_lane_ignored: assert property (p_lane_ignored)
      else $error("write without byte lane changed a register");
   property p_pin_state_okay;
      (wr_fire && state_reg.aw_idx == IDX_W'(`ACIO_IDX_PIN_STATE))
         |=> (s_axi_bresp == `ACIO_RESP_OKAY);
   endproperty
   a_pin_state_okay: assert property (p_pin_state_okay)
      else $error("pin-state write not answered okay");
   property p_pin_view;
      (!manual_reset && !sw_standby) |=> (state_reg.pin_state == $past(pin_view));
   endproperty
   a_pin_view: assert property (p_pin_view)
      else $error("pin-state value wrong");
   property p_pin_hold;
      ((manual_reset || sw_standby) && !state_reg.hws_sync) |=> $stable(state_reg.pin_state);
   endproperty
   a_pin_hold: assert property (p_pin_hold)
      else $error("pin-state changed while held");
   property p_reduced;
      REDUCED |-> (state_reg.mode_class == acio_pkg::CLASS_ADDR);
   endproperty
   a_reduced: assert property (p_reduced)
      else $error("reduced variant left address mode");
   // bus handshake checks
   property p_write_answer;
      wr_fire |=> s_axi_bvalid ##0 (!s_axi_awready && !s_axi_wready);
   endproperty
   a_write_answer: assert property (p_write_answer)
      else $error("write response not one cycle after fire");
   property p_read_answer;
      (s_axi_arvalid && s_axi_arready) |=> (s_axi_rvalid && !s_axi_arready);
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read data not one cycle after address");

   // main scenarios reached
   c_dir_write: cover property (wr_fire && wr_allowed
      && state_reg.aw_idx == IDX_W'(`ACIO_IDX_DIRECTION));
   c_manual_reset: cover property (manual_reset && state_reg.dir != '0);
   c_hw_standby: cover property (state_reg.hws_sync && state_reg.latch == '0);
   c_addr_float: cover property (sw_standby && !standby_output_keep
      && state_reg.mode_class == acio_pkg::CLASS_ADDR && port_pin_oe == '0);
   c_gpio_read: cover property (s_axi_rvalid && state_reg.mode_class == acio_pkg::CLASS_GPIO
      && state_reg.rd_idx == IDX_W'(`ACIO_IDX_PIN_STATE));
endmodule : address_capable_io_port

/* address_capable_io_port_bench.sv */
// self-checking bench of the address capable port
`timescale 1ns/10ps
`include "acio_defines.svh"
module address_capable_io_port_bench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [17:0] awaddr = '0, araddr = '0;
   // responses are always accepted
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp;
   logic manual_reset = 1'b0, sw_standby = 1'b0, keep = 1'b0, hw_standby = 1'b0;
   logic [2:0] mode_pins = 3'h7;
   logic [7:0] ext_val = 8'h00, ext_en = 8'hFF, addr_val = 8'h00;
   logic [7:0] addr_bus, pin_in, pin_out, pin_oe, pullup_on;
   int err_count = 0;
   int checks = 0;
   int cycles = 0;
   // modes with every pin an address output
   logic [2:0] mode_list [3] = '{3'h1, 3'h4, 3'h5};

   address_capable_io_port uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .manual_reset(manual_reset), .sw_standby(sw_standby),
      .standby_output_keep(keep), .hw_standby(hw_standby), .mode_pins(mode_pins),
      .addr_bus(addr_bus), .port_pin_in(pin_in), .port_pin_out(pin_out),
      .port_pin_oe(pin_oe), .pullup_on(pullup_on));

   pin_partner far_side (.aclk(aclk), .port_pin_out(pin_out), .port_pin_oe(pin_oe),
      .pullup_on(pullup_on), .ext_val(ext_val), .ext_en(ext_en), .addr_val(addr_val),
      .port_pin_in(pin_in), .addr_bus(addr_bus));

   // 40 MHz clock
   always #12.5 aclk = ~aclk;

   // hang guard
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         results();
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // one write; address and data offered together, each released when taken
   task automatic wr(input logic [15:0] idx, input logic [7:0] val, input logic [1:0] er);
      logic da, dw, db, a, w;
      logic [1:0] resp;
      da = 1'b0;
      dw = 1'b0;
      db = 1'b0;
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, val};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(da && dw))
      begin
         @(negedge aclk);
         a = awvalid && awready;
         w = wvalid && wready;
         @(posedge aclk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         da = da | a;
         dw = dw | w;
      end
      while (!db)
      begin
         @(negedge aclk);
         db = bvalid;
         resp = bresp;
         @(posedge aclk);
      end
      check("bresp", 32'(resp), 32'(er));
   endtask : wr

   // one read compared with its expected byte and response
   task automatic rd(input logic [15:0] idx, input logic [7:0] ev, input logic [1:0] er);
      logic da, dr;
      logic [31:0] data;
      logic [1:0] resp;
      da = 1'b0;
      dr = 1'b0;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      while (!da)
      begin
         @(negedge aclk);
         da = arready;
         @(posedge aclk);
      end
      arvalid <= 1'b0;
      while (!dr)
      begin
         @(negedge aclk);
         dr = rvalid;
         data = rdata;
         resp = rresp;
         @(posedge aclk);
      end
      check("rdata", data, {24'h0, ev});
      check("rresp", 32'(resp), 32'(er));
   endtask : rd

   // pin drive after the change has settled
   task automatic pins(input logic [7:0] oe, input logic [7:0] out, input logic [7:0] pu);
      repeat (8) @(posedge aclk);
      @(negedge aclk);
      check("oe", 32'(pin_oe), 32'(oe));
      check("out", 32'(pin_out & pin_oe), 32'(out));
      check("pullup", 32'(pullup_on), 32'(pu));
      @(posedge aclk);
   endtask : pins

   task automatic results();
      $display("comparisons %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results

   // main sequence
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(`ACIO_IDX_DIRECTION, `ACIO_UNDEF_READ, `ACIO_RESP_OKAY);
      rd(`ACIO_IDX_OUTPUT_LATCH, 8'h00, `ACIO_RESP_OKAY);
      rd(`ACIO_IDX_PULLUP_ENABLE, 8'h00, `ACIO_RESP_OKAY);
      rd(16'h0000, 8'h00, `ACIO_RESP_SLVERR);
      // general port setup in mode 7, whole-byte direction write
      wr(`ACIO_IDX_DIRECTION, 8'hF0, `ACIO_RESP_OKAY);
      wr(`ACIO_IDX_OUTPUT_LATCH, 8'hA5, `ACIO_RESP_OKAY);
      wr(`ACIO_IDX_PULLUP_ENABLE, 8'hFF, `ACIO_RESP_OKAY);
      rd(`ACIO_IDX_OUTPUT_LATCH, 8'hA5, `ACIO_RESP_OKAY);
      rd(`ACIO_IDX_PULLUP_ENABLE, 8'hFF, `ACIO_RESP_OKAY);
      rd(`ACIO_IDX_DIRECTION, `ACIO_UNDEF_READ, `ACIO_RESP_OKAY);
      ext_en <= 8'h00;
      pins(8'hF0, 8'hA0, 8'h0F);
      rd(`ACIO_IDX_PIN_STATE, 8'hAF, `ACIO_RESP_OKAY);
      ext_en <= 8'hFF;
      ext_val <= 8'h36;
      pins(8'hF0, 8'hA0, 8'h0F);
      rd(`ACIO_IDX_PIN_STATE, 8'hA6, `ACIO_RESP_OKAY);
      wr(`ACIO_IDX_PIN_STATE, 8'hFF, `ACIO_RESP_OKAY);
      rd(`ACIO_IDX_OUTPUT_LATCH, 8'hA5, `ACIO_RESP_OKAY);
      // write without byte lane 0 is answered but ignored
      wstrb <= 4'h0;
      wr(`ACIO_IDX_OUTPUT_LATCH, 8'h11, `ACIO_RESP_OKAY);
      wstrb <= 4'hF;
      rd(`ACIO_IDX_OUTPUT_LATCH, 8'hA5, `ACIO_RESP_OKAY);
      // manual reset keeps the registers and freezes the pin state
      manual_reset <= 1'b1;
      ext_val <= 8'h39;
      wr(`ACIO_IDX_OUTPUT_LATCH, 8'h3C, `ACIO_RESP_OKAY);
      pins(8'hF0, 8'hA0, 8'h0F);
      rd(`ACIO_IDX_PIN_STATE, 8'hA6, `ACIO_RESP_OKAY);
      manual_reset <= 1'b0;
      rd(`ACIO_IDX_OUTPUT_LATCH, 8'hA5, `ACIO_RESP_OKAY);
      rd(`ACIO_IDX_PIN_STATE, 8'hA9, `ACIO_RESP_OKAY);
      // address modes
      mode_pins <= `ACIO_MODE_6;
      addr_val <= 8'h5A;
      pins(8'hF0, 8'h50, 8'h0F);
      mode_pins <= `ACIO_MODE_2;
      pins(8'hF0, 8'h50, 8'h0F);
      mode_pins <= `ACIO_MODE_3;
      pins(8'hF0, 8'hA0, 8'h0F);
      foreach (mode_list[i])
      begin
         mode_pins <= mode_list[i];
         pins(8'hFF, 8'h5A, 8'h00);
      end
      // software standby with and without output keep
      sw_standby <= 1'b1;
      keep <= 1'b1;
      repeat (4) @(posedge aclk);
      addr_val <= 8'hC3;
      pins(8'hFF, 8'h5A, 8'h00);
      keep <= 1'b0;
      pins(8'h00, 8'h00, 8'h00);
      sw_standby <= 1'b0;
      pins(8'hFF, 8'hC3, 8'h00);
      // hardware standby clears latch, pull-up enable and pin drive
      mode_pins <= `ACIO_MODE_7;
      pins(8'hF0, 8'hA0, 8'h0F);
      hw_standby <= 1'b1;
      pins(8'h00, 8'h00, 8'h00);
      hw_standby <= 1'b0;
      pins(8'h00, 8'h00, 8'h00);
      rd(`ACIO_IDX_OUTPUT_LATCH, 8'h00, `ACIO_RESP_OKAY);
      rd(`ACIO_IDX_PULLUP_ENABLE, 8'h00, `ACIO_RESP_OKAY);
      rd(`ACIO_IDX_PIN_STATE, 8'h39, `ACIO_RESP_OKAY);
      results();
   end

endmodule : address_capable_io_port_bench

/* pin_ctrl_if.sv */
// carrier of port configuration from register file to pin multiplexer
`timescale 1ns/10ps
interface pin_ctrl_if #(
   parameter int WIDTH = 8
);
   logic [WIDTH-1:0] dir;
   logic [WIDTH-1:0] latch;
   logic [WIDTH-1:0] pull_cfg;
   logic [WIDTH-1:0] addr;
   acio_pkg::mode_class_type mode_class;
   logic sw_standby;
   logic keep;
   logic hw_standby;
   // register file side
   modport source (
      output dir, latch, pull_cfg, addr, mode_class, sw_standby, keep, hw_standby
   );
   // pin multiplexer side
   modport sink (
      input dir, latch, pull_cfg, addr, mode_class, sw_standby, keep, hw_standby
   );
endinterface : pin_ctrl_if

/* pin_partner.sv */
// model of the pins' outside world and of the bus controller's address source
`timescale 1ns/10ps
module pin_partner (
   // clock
   input wire logic aclk,
   // device pin drive
   input wire logic [7:0] port_pin_out,
   input wire logic [7:0] port_pin_oe,
   input wire logic [7:0] pullup_on,
   // outside drive set by the bench
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] addr_val,
   // towards the device
   output logic [7:0] port_pin_in,
   output logic [7:0] addr_bus
);
   // wire level: device drive wins, then outside drive, then pull-up
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (port_pin_oe[i])
            port_pin_in[i] = port_pin_out[i];
         else if (ext_en[i])
            port_pin_in[i] = ext_val[i];
         else if (pullup_on[i])
            port_pin_in[i] = 1'b1;
         else
            port_pin_in[i] = ~port_pin_out[i]; // floating: never the last value
      end
   end

   // bus controller address, launched on the system clock
   always_ff @(posedge aclk)
   begin
      addr_bus <= addr_val;
   end
endmodule : pin_partner

/* port_pin_mux.sv */
// pin function multiplexer: drive, enable and pull-up per pin
`timescale 1ns/10ps
`include "acio_defines.svh"
module port_pin_mux #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // configuration
   pin_ctrl_if.sink ctl,
   // pin drive
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe,
   output logic [WIDTH-1:0] pullup_on
);
   typedef struct packed {
      logic [WIDTH-1:0] out;
      logic [WIDTH-1:0] oe;
      logic [WIDTH-1:0] pull;
   } mux_state_type;

   mux_state_type state_reg;
   mux_state_type state_next;
   logic [WIDTH-1:0] addr_mask;

   // pins carrying address bits in this mode
   always_comb
   begin
      case (ctl.mode_class)
         acio_pkg::CLASS_ADDR: addr_mask = '1;
         acio_pkg::CLASS_ADDR_DDR: addr_mask = ctl.dir;
         default: addr_mask = '0;
      endcase
   end

   // pin function per mode and standby state
   always_comb
   begin
      state_next = state_reg;
      state_next.out = (addr_mask & ctl.addr) | (~addr_mask & ctl.latch);
      state_next.oe = addr_mask | ctl.dir;
      state_next.pull = (ctl.mode_class == acio_pkg::CLASS_ADDR) ? '0 : (~ctl.dir & ctl.pull_cfg);
      if (ctl.sw_standby)
      begin
         // address pins hold their value or float
         state_next.out = (addr_mask & state_reg.out) | (~addr_mask & ctl.latch);
         state_next.oe = (ctl.keep ? (addr_mask & state_reg.oe) : '0) | (~addr_mask & ctl.dir);
      end
      if (ctl.hw_standby)
      begin
         state_next.oe = '0;
         state_next.pull = '0;
      end
   end

   // state register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign pin_out = state_reg.out;
   assign pin_oe = state_reg.oe;
   assign pullup_on = state_reg.pull;

   default clocking mux_clk @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_addr_mode_drives;
      (aresetn && ctl.mode_class == acio_pkg::CLASS_ADDR // skip the edge that leaves reset
         && !ctl.sw_standby && !ctl.hw_standby)
         |=> (pin_oe == '1 && pin_out == $past(ctl.addr));
   endproperty
   a_addr_mode_drives: assert property (p_addr_mode_drives)
      else $error("address mode pin not driving address");
   property p_addr_ddr_mode;
      (ctl.mode_class == acio_pkg::CLASS_ADDR_DDR && !ctl.sw_standby && !ctl.hw_standby)
         |=> (pin_oe == $past(ctl.dir) && (pin_out & pin_oe) == ($past(ctl.addr) & pin_oe));
   endproperty
   a_addr_ddr_mode: assert property (p_addr_ddr_mode)
      else $error("mixed address mode pin wrong");
   property p_gpio_mode;
      (ctl.mode_class == acio_pkg::CLASS_GPIO && !ctl.hw_standby)
         |=> (pin_oe == $past(ctl.dir) && pin_out == $past(ctl.latch));
   endproperty
   a_gpio_mode: assert property (p_gpio_mode)
      else $error("general port pin wrong");
   property p_pull_off_addr;
      (ctl.mode_class == acio_pkg::CLASS_ADDR) |=> (pullup_on == '0);
   endproperty
   a_pull_off_addr: assert property (p_pull_off_addr)
      else $error("pull-up on in address mode");
   property p_pull_rule;
      (ctl.mode_class != acio_pkg::CLASS_ADDR && !ctl.hw_standby)
         |=> (pullup_on == (~$past(ctl.dir) & $past(ctl.pull_cfg)));
   endproperty
   a_pull_rule: assert property (p_pull_rule)
      else $error("pull-up state wrong");
   property p_standby_float;
      (ctl.sw_standby && !ctl.keep && ctl.mode_class == acio_pkg::CLASS_ADDR)
         |=> (pin_oe == '0);
   endproperty
   a_standby_float: assert property (p_standby_float)
      else $error("address pin driven in standby without keep");
endmodule : port_pin_mux
